// ===== hw/tks_scan_ctrl.sv
// Touch scan controller: registers, conversion sequencer and counters.
`timescale 1ns/1ps

module tks_scan_ctrl
    import tks_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire logic                ce,
    input  wire logic [7:0]          sfrAddr,
    input  wire logic                sfrWe,
    input  wire logic [7:0]          sfrWdata,
    input  wire logic                sfrRe,
    output logic      [7:0]          sfrRdata,
    input  wire logic                rckOsc,
    input  wire logic                tckOsc,
    input  wire logic                chargeFull,
    output logic                     senseEnable,
    output logic                     methodSel,
    output logic                     refKeyEnable,
    output logic      [PAD_N-1:0]    padEnable,
    output logic      [2:0]          referenceSetting,
    output logic      [1:0]          oscillatorSpeed,
    output logic      [2:0]          hopCode,
    output logic                     converting,
    output logic                     touchIrq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        tks_state_t       st;
        logic [7:0]       misc;
        logic             irqFlag;
        logic [7:0]       tctl;
        logic             eoc;
        logic [7:0]       channel_select;
        logic [7:0]       refLo;
        logic [3:0]       refHi;
        logic [7:0]       auxiliary_control_two;
        logic [7:0]       auxiliary_control_one;
        logic [CNT_W-1:0] refCnt;
        logic [CNT_W-1:0] dataCnt;
        logic [CNT_W-1:0] result;
        logic             wasOn;
        logic [7:0]       rdata;
        logic [PAD_N-1:0] pads;
        logic             refKey;
        logic             powered;
        logic [2:0]       hop;
        logic             busy;
        logic [1:0]       speed;
    } tks_regs_t;

    localparam tks_regs_t RST_REGS = '{
        st:      ST_IDLE,
        misc:    RST_MISC,
        tctl:    RST_TCTL,
        channel_select:   RST_CHANNEL_SELECT,
        refLo:   RST_REFLO,
        refHi:   RST_REFHI,
        auxiliary_control_two:    RST_AUXILIARY_CONTROL_TWO,
        auxiliary_control_one:    RST_AUXILIARY_CONTROL_ONE,
        default: '0
    };

    tks_regs_t regs_r;
    tks_regs_t regs_nxt;

    logic rckRise;
    logic tckRise;
    logic chargeLvl;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [CNT_W-1:0] satAdd(
        input logic [CNT_W-1:0] cnt,
        input logic [1:0]       step
    );
        logic [CNT_W:0] sum;
        sum = {1'b0, cnt} + {{(CNT_W-1){1'b0}}, step};
        if (sum[CNT_W]) begin
            satAdd = {CNT_W{1'b1}};
        end else begin
            satAdd = sum[CNT_W-1:0];
        end
    endfunction

    function automatic logic [PAD_N-1:0] padDecode(
        input logic [CH_W-1:0] chan
    );
        padDecode       = '0;
        padDecode[chan] = 1'b1;
    endfunction

    // ----------------------------------------------------------------
    // Oscillator and comparator synchronisers
    // ----------------------------------------------------------------
    tks_edge_sync u_rckSync (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ce      (ce),
        .asyncIn (rckOsc),
        .level   (),
        .rise    (rckRise)
    );

    tks_edge_sync u_tckSync (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ce      (ce),
        .asyncIn (tckOsc),
        .level   (),
        .rise    (tckRise)
    );

    tks_edge_sync u_chgSync (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ce      (ce),
        .asyncIn (chargeFull),
        .level   (chargeLvl),
        .rise    ()
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic             startReq;
        logic             endEvt;
        logic             setIrq;
        logic             isStk;
        logic             pdOld;
        logic             pdNew;
        logic [CNT_W-1:0] target;
        logic [1:0]       step;

        regs_nxt = regs_r;
        startReq = 1'b0;
        endEvt   = 1'b0;
        setIrq   = 1'b0;
        isStk    = regs_r.auxiliary_control_two[MODE_BIT];
        pdOld    = regs_r.tctl[PD_BIT];
        target   = {regs_r.refHi, regs_r.refLo};
        step     = 2'h1;

        // Register reads: data is registered, valid one cycle later.
        if (sfrRe) begin
            if (sfrAddr == ADDR_MISC) begin
                regs_nxt.rdata = regs_r.misc;
            end else if (sfrAddr == ADDR_INTF) begin
                regs_nxt.rdata = 8'h00;
                regs_nxt.rdata[IRQ_BIT] = regs_r.irqFlag;
            end else if (sfrAddr == ADDR_SHARED) begin
                regs_nxt.rdata = {4'h0, regs_r.result[11:8]};
            end else if (sfrAddr == ADDR_CNTLO) begin
                regs_nxt.rdata = regs_r.result[7:0];
            end else if (sfrAddr == ADDR_TCTL) begin
                regs_nxt.rdata = regs_r.tctl;
                regs_nxt.rdata[EOC_BIT] = regs_r.eoc;
            end else if (sfrAddr == ADDR_CHANNEL_SELECT) begin
                regs_nxt.rdata = regs_r.channel_select;
            end else if (sfrAddr == ADDR_REFLO) begin
                regs_nxt.rdata = regs_r.refLo;
            end else if (sfrAddr == ADDR_REFHI) begin
                regs_nxt.rdata = {4'h0, regs_r.refHi};
            end else if (sfrAddr == ADDR_AUXILIARY_CONTROL_TWO) begin
                regs_nxt.rdata = regs_r.auxiliary_control_two;
            end else if (sfrAddr == ADDR_AUXILIARY_CONTROL_ONE) begin
                regs_nxt.rdata = regs_r.auxiliary_control_one;
            end else begin
                regs_nxt.rdata = 8'h00;
            end
        end

        // Register writes.
        if (sfrWe) begin
            if (sfrAddr == ADDR_MISC) begin
                regs_nxt.misc = sfrWdata;
            end else if (sfrAddr == ADDR_INTF) begin
                if (!sfrWdata[IRQ_BIT]) begin
                    regs_nxt.irqFlag = 1'b0;
                end
            end else if (sfrAddr == ADDR_TCTL) begin
                regs_nxt.tctl = sfrWdata;
                regs_nxt.tctl[EOC_BIT] = 1'b0;
            end else if (sfrAddr == ADDR_CHANNEL_SELECT) begin
                regs_nxt.channel_select = sfrWdata;
            end else if (sfrAddr == ADDR_REFLO) begin
                regs_nxt.refLo = sfrWdata;
            end else if (sfrAddr == ADDR_REFHI) begin
                regs_nxt.refHi = sfrWdata[3:0];
            end else if (sfrAddr == ADDR_AUXILIARY_CONTROL_TWO) begin
                regs_nxt.auxiliary_control_two = sfrWdata;
            end else if (sfrAddr == ADDR_AUXILIARY_CONTROL_ONE) begin
                regs_nxt.auxiliary_control_one = sfrWdata;
                if (sfrWdata[START_BIT]) begin
                    if (pdOld) begin
                        regs_nxt.auxiliary_control_one[START_BIT] = 1'b0;
                    end else begin
                        startReq = 1'b1;
                    end
                end
            end
        end

        pdNew = regs_nxt.tctl[PD_BIT];

        // The first release of power-down flags an interrupt once.
        if (pdOld && !pdNew && !regs_r.wasOn) begin
            setIrq         = 1'b1;
            regs_nxt.wasOn = 1'b1;
        end

        // Doubling applies only to the self-oscillator count.
        if (isStk && regs_r.tctl[DBL_BIT]) begin
            step = 2'h2;
        end

        // Conversion sequencer.
        case (regs_r.st)
            ST_IDLE: begin
                regs_nxt.st = ST_IDLE;
            end
            ST_RUN: begin
                if (pdOld) begin
                    // Power-down aborts; no result and no flag.
                    regs_nxt.st = ST_IDLE;
                    regs_nxt.auxiliary_control_one[START_BIT] = 1'b0;
                end else begin
                    if (isStk) begin
                        endEvt = (regs_r.refCnt == target);
                        if (rckRise && !endEvt) begin
                            regs_nxt.refCnt = regs_r.refCnt + 1'b1;
                        end
                    end else begin
                        // Reference count is ignored here.
                        endEvt = chargeLvl;
                    end
                    if (tckRise && !endEvt) begin
                        regs_nxt.dataCnt = satAdd(regs_r.dataCnt, step);
                    end
                    if (endEvt) begin
                        regs_nxt.st     = ST_IDLE;
                        regs_nxt.result = regs_r.dataCnt;
                        regs_nxt.eoc    = 1'b1;
                        regs_nxt.auxiliary_control_one[START_BIT] = 1'b0;
                        setIrq = 1'b1;
                    end
                end
            end
            default: begin
                regs_nxt.st = ST_IDLE;
            end
        endcase

        // A start restarts both counters and clears the done flag.
        if (startReq) begin
            regs_nxt.st      = ST_RUN;
            regs_nxt.refCnt  = '0;
            regs_nxt.dataCnt = '0;
            regs_nxt.eoc     = 1'b0;
            regs_nxt.irqFlag = 1'b0;
            if (regs_r.misc[HOP_BIT]) begin
                regs_nxt.hop = {regs_r.hop[1:0],
                                regs_r.hop[2] ^ regs_r.hop[1]};
            end
        end

        // Hop code stays at zero while hopping is off.
        if (!regs_r.misc[HOP_BIT]) begin
            regs_nxt.hop = 3'h0;
        end else if (regs_nxt.hop == 3'h0) begin
            regs_nxt.hop = HOP_SEED;
        end

        // A set in the same cycle as a clear wins.
        if (setIrq) begin
            regs_nxt.irqFlag = 1'b1;
        end

        // Analogue routing follows the register values just written.
        regs_nxt.powered = !pdNew;
        regs_nxt.refKey  = !pdNew && regs_nxt.auxiliary_control_two[REFKEY_BIT];
        if (!pdNew && !regs_nxt.auxiliary_control_two[REFKEY_BIT]) begin
            regs_nxt.pads = padDecode(regs_nxt.channel_select[CH_W-1:0]);
        end else begin
            regs_nxt.pads = '0;
        end
        if (regs_nxt.auxiliary_control_two[MODE_BIT]) begin
            regs_nxt.speed = regs_nxt.tctl[SPD_LSB+1:SPD_LSB];
        end else begin
            regs_nxt.speed = 2'b00;
        end
        // Busy is kept in a flop so that the output needs no decoding.
        regs_nxt.busy = (regs_nxt.st == ST_RUN);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            regs_r <= RST_REGS;
        end else if (ce) begin
            regs_r <= regs_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sfrRdata         = regs_r.rdata;
    assign senseEnable      = regs_r.powered;
    assign methodSel        = regs_r.auxiliary_control_two[MODE_BIT];
    assign refKeyEnable     = regs_r.refKey;
    assign padEnable        = regs_r.pads;
    assign referenceSetting = regs_r.tctl[REFSET_LSB+2:REFSET_LSB];
    assign oscillatorSpeed  = regs_r.speed;
    assign hopCode          = regs_r.hop;
    assign converting       = regs_r.busy;
    assign touchIrq         = regs_r.irqFlag;

endmodule // tks_scan_ctrl

// ===== inc/tks_pkg.sv
// Package of constants and types for the capacitive touch scan controller.
package tks_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MISC   = 8'h94;
    localparam logic [7:0] ADDR_INTF   = 8'h95;
    localparam logic [7:0] ADDR_SHARED = 8'hAA;
    localparam logic [7:0] ADDR_CNTLO  = 8'hAC;
    localparam logic [7:0] ADDR_TCTL   = 8'hAD;
    localparam logic [7:0] ADDR_CHANNEL_SELECT  = 8'hAE;
    localparam logic [7:0] ADDR_REFLO  = 8'hB4;
    localparam logic [7:0] ADDR_REFHI  = 8'hB5;
    localparam logic [7:0] ADDR_AUXILIARY_CONTROL_TWO   = 8'hF7;
    localparam logic [7:0] ADDR_AUXILIARY_CONTROL_ONE   = 8'hF8;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int HOP_BIT    = 6;
    localparam int IRQ_BIT    = 5;
    localparam int PD_BIT     = 7;
    localparam int EOC_BIT    = 6;
    localparam int SPD_LSB    = 4;
    localparam int DBL_BIT    = 3;
    localparam int REFSET_LSB = 0;
    localparam int MODE_BIT   = 3;
    localparam int REFKEY_BIT = 0;
    localparam int START_BIT  = 5;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int CNT_W = 12;
    localparam int CH_W  = 4;
    localparam int PAD_N = 16;

    localparam logic [7:0] RST_MISC  = 8'h00;
    localparam logic [7:0] RST_TCTL  = 8'h84;
    localparam logic [7:0] RST_CHANNEL_SELECT = 8'hFF;
    localparam logic [7:0] RST_REFLO = 8'hFF;
    localparam logic [3:0] RST_REFHI = 4'h0;
    localparam logic [7:0] RST_AUXILIARY_CONTROL_TWO  = 8'h0E;
    localparam logic [7:0] RST_AUXILIARY_CONTROL_ONE  = 8'h00;
    localparam logic [2:0] HOP_SEED  = 3'h1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int EOC_FALL_NS   = 3000;
    localparam int EOC_FALL_CYC  = EOC_FALL_NS / CLK_PERIOD_NS;
    localparam int CTK_GAP_US    = 50;
    localparam int CTK_GAP_CYC   = (CTK_GAP_US * 1000) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN
    } tks_state_t;

endpackage

// ===== hw/tks_edge_sync.sv
// Two-flop synchroniser with a registered rising-edge pulse.
`timescale 1ns/1ps

module tks_edge_sync (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic asyncIn,
    output logic      level,
    output logic      rise
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
    } tks_sync_t;

    tks_sync_t sync_r;
    tks_sync_t sync_nxt;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        sync_nxt      = sync_r;
        sync_nxt.s1   = asyncIn;
        sync_nxt.s2   = sync_r.s1;
        sync_nxt.s3   = sync_r.s2;
        // Only the second and third stages are looked at, never the first.
        sync_nxt.rise = sync_r.s2 & ~sync_r.s3;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_r <= '0;
        end else if (ce) begin
            sync_r <= sync_nxt;
        end
    end

    assign level = sync_r.s2;
    assign rise  = sync_r.rise;

endmodule // tks_edge_sync

// ===== verif/tks_scan_ctrl_monitor.sv
// Port checker for the touch scan controller.
`timescale 1ns/1ps
module tks_scan_ctrl_monitor
    import tks_pkg::*;
(
    input wire logic             sys_clk,
    input wire logic             srst,
    input wire logic             ce,
    input wire logic [7:0]       sfrAddr,
    input wire logic             sfrWe,
    input wire logic [7:0]       sfrWdata,
    input wire logic             sfrRe,
    input wire logic [7:0]       sfrRdata,
    input wire logic             rckOsc,
    input wire logic             tckOsc,
    input wire logic             chargeFull,
    input wire logic             senseEnable,
    input wire logic             methodSel,
    input wire logic             refKeyEnable,
    input wire logic [PAD_N-1:0] padEnable,
    input wire logic [2:0]       referenceSetting,
    input wire logic [1:0]       oscillatorSpeed,
    input wire logic [2:0]       hopCode,
    input wire logic             converting,
    input wire logic             touchIrq
);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic startWr;
    logic tctlWr;
    assign startWr = ce && sfrWe && sfrAddr == ADDR_AUXILIARY_CONTROL_ONE
                     && sfrWdata[START_BIT];
    assign tctlWr = ce && sfrWe && sfrAddr == ADDR_TCTL;
    a_pad_off_down: assert property (
        !senseEnable |-> padEnable == '0) else $error("pad while off");
    a_refkey_isolate: assert property (
        refKeyEnable |-> padEnable == '0) else $error("pad with refkey");
    a_pad_one_hot: assert property (
        senseEnable && !refKeyEnable |-> $onehot(padEnable))
        else $error("pad select not one-hot");
    a_speed_ctk_zero: assert property (
        !methodSel |-> oscillatorSpeed == 2'h0) else $error("speed in ctk");
    a_start_runs: assert property (
        startWr && senseEnable |=> converting) else $error("no start");
    a_start_refused: assert property (
        startWr && !senseEnable |=> !converting) else $error("start off");
    a_power_bit: assert property (
        tctlWr |=> senseEnable == !$past(sfrWdata[PD_BIT]))
        else $error("power bit not followed");
    a_end_sets_irq: assert property (
        $fell(converting) && senseEnable |-> touchIrq)
        else $error("no flag at end");
    a_start_clr_irq: assert property (
        startWr && senseEnable && !converting |=> !touchIrq)
        else $error("flag kept at start");
    a_eoc_low_busy: assert property (
        ce && sfrRe && sfrAddr == ADDR_TCTL && converting
        |=> !sfrRdata[EOC_BIT]) else $error("done while busy");
    a_upper_zero: assert property (
        ce && sfrRe && sfrAddr == ADDR_SHARED |=> sfrRdata[7:4] == 4'h0)
        else $error("upper nibble set");
    cover property ($fell(converting) && touchIrq);
    cover property (startWr && !senseEnable);
    cover property (refKeyEnable && senseEnable && converting);
endmodule // tks_scan_ctrl_monitor

// ===== verif/tks_pad_model.sv
// Behavioural model of pads, sensing oscillators and charge comparator.
`timescale 1ns/1ps
module tks_pad_model
    import tks_pkg::*;
#(
    parameter int RCK_HALF_NS = 100,
    parameter int TCK_HALF_NS = 25,
    parameter int CHARGE_NS   = 2000
) (
    input  wire logic             senseEnable,
    input  wire logic             methodSel,
    input  wire logic             refKeyEnable,
    input  wire logic [PAD_N-1:0] padEnable,
    input  wire logic             converting,
    output logic                  rckOsc,
    output logic                  tckOsc,
    output logic                  chargeFull
);
    // ----------------------------------------------------------------
    // Oscillators and comparator
    // ----------------------------------------------------------------
    // Oscillators stop low when unpowered, so no stale edge is counted.
    logic keyOn;
    assign keyOn = senseEnable && (refKeyEnable || |padEnable);
    initial begin
        rckOsc = 1'b0;
        #3;
        forever begin
            #(RCK_HALF_NS);
            rckOsc = senseEnable ? ~rckOsc : 1'b0;
        end
    end
    initial begin
        tckOsc = 1'b0;
        #7;
        forever begin
            #(TCK_HALF_NS);
            tckOsc = keyOn ? ~tckOsc : 1'b0;
        end
    end
    initial begin
        chargeFull = 1'b0;
        forever begin
            @(posedge converting);
            if (!methodSel) begin
                #(CHARGE_NS);
                chargeFull = 1'b1;
                @(negedge converting);
                chargeFull = 1'b0;
            end
        end
    end
endmodule // tks_pad_model

// ===== verif/tks_scan_ctrl_tb.sv
// Self-checking testbench of the touch scan controller.
`timescale 1ns/1ps
module tks_scan_ctrl_tb
    import tks_pkg::*;
;
    logic             sys_clk;
    logic             srst;
    logic             ce;
    logic [7:0]       sfrAddr;
    logic             sfrWe;
    logic [7:0]       sfrWdata;
    logic             sfrRe;
    logic [7:0]       sfrRdata;
    logic             rckOsc;
    logic             tckOsc;
    logic             chargeFull;
    logic             senseEnable;
    logic             methodSel;
    logic             refKeyEnable;
    logic [PAD_N-1:0] padEnable;
    logic [2:0]       referenceSetting;
    logic [1:0]       oscillatorSpeed;
    logic [2:0]       hopCode;
    logic             converting;
    logic             touchIrq;
    logic [7:0]       rdVal;
    int               error_cnt = 0;
    int               cmp_count = 0;

    tks_scan_ctrl i_tks_scan_ctrl (.sys_clk(sys_clk), .srst(srst), .ce(ce),
        .sfrAddr(sfrAddr), .sfrWe(sfrWe), .sfrWdata(sfrWdata),
        .sfrRe(sfrRe), .sfrRdata(sfrRdata), .rckOsc(rckOsc),
        .tckOsc(tckOsc), .chargeFull(chargeFull),
        .senseEnable(senseEnable), .methodSel(methodSel),
        .refKeyEnable(refKeyEnable), .padEnable(padEnable),
        .referenceSetting(referenceSetting),
        .oscillatorSpeed(oscillatorSpeed), .hopCode(hopCode),
        .converting(converting), .touchIrq(touchIrq));
    tks_pad_model i_tks_pad_model (.senseEnable(senseEnable),
        .methodSel(methodSel), .refKeyEnable(refKeyEnable),
        .padEnable(padEnable), .converting(converting), .rckOsc(rckOsc),
        .tckOsc(tckOsc), .chargeFull(chargeFull));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfrAddr = a;
        sfrWdata = d;
        sfrWe = 1'b1;
        @(negedge sys_clk);
        sfrWe = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk);
        sfrAddr = a;
        sfrRe = 1'b1;
        @(negedge sys_clk);
        sfrRe = 1'b0;
        rdVal = sfrRdata;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkreg(input logic [7:0] a, m, exp);
        rd(a);
        chk({8'h00, rdVal & m}, {8'h00, exp});
    endtask
    task automatic chkr(input logic [11:0] got, input int lo, hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: count %0d", $time, got);
        end
    endtask
    // Software may not poll the done flag early, so polling starts late.
    task automatic finish_conv(input int lo, hi);
        logic [11:0] c;
        int n;
        repeat (EOC_FALL_CYC) @(negedge sys_clk);
        n = 0;
        rd(ADDR_TCTL);
        while (rdVal[EOC_BIT] !== 1'b1 && n < 4000) begin
            rd(ADDR_TCTL);
            n++;
        end
        if (rdVal[EOC_BIT] !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: no end of conversion", $time);
            print_verdict();
        end else begin
            chkreg(ADDR_AUXILIARY_CONTROL_ONE, 8'h20, 8'h00);
            chk({15'h0, touchIrq}, 16'h1);
            rd(ADDR_CNTLO);
            c[7:0] = rdVal;
            rd(ADDR_SHARED);
            c[11:8] = rdVal[3:0];
            chkr(c, lo, hi);
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        sfrAddr = 8'h00;
        sfrWe = 1'b0;
        sfrWdata = 8'h00;
        sfrRe = 1'b0;
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        chkreg(ADDR_MISC, 8'hFF, 8'h00);
        chkreg(ADDR_TCTL, 8'hFF, 8'h84);
        chkreg(ADDR_CHANNEL_SELECT, 8'hFF, 8'hFF);
        chkreg(ADDR_REFLO, 8'hFF, 8'hFF);
        ce = 1'b0;
        wr(ADDR_REFLO, 8'h55);
        ce = 1'b1;
        chkreg(ADDR_REFLO, 8'hFF, 8'hFF);
        chkreg(ADDR_REFHI, 8'h0F, 8'h00);
        chkreg(ADDR_AUXILIARY_CONTROL_TWO, 8'hFF, 8'h0E);
        chkreg(ADDR_INTF, 8'h20, 8'h00);
        chkreg(8'h00, 8'hFF, 8'h00);
        chk({11'h0, methodSel, senseEnable, referenceSetting}, 16'h14);
        wr(ADDR_AUXILIARY_CONTROL_ONE, 8'h20);
        chk({15'h0, converting}, 16'h0);
        chkreg(ADDR_AUXILIARY_CONTROL_ONE, 8'h20, 8'h00);
        wr(ADDR_TCTL, 8'h04);
        chkreg(ADDR_INTF, 8'h20, 8'h20);
        chk({15'h0, senseEnable}, 16'h1);
        wr(ADDR_INTF, 8'hDF);
        chk({15'h0, touchIrq}, 16'h0);
        wr(ADDR_TCTL, 8'h84);
        chk(padEnable, 16'h0);
        wr(ADDR_TCTL, 8'h04);
        chk({15'h0, touchIrq}, 16'h0);
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_CHANNEL_SELECT, {4'hF, i[3:0]});
            chk(padEnable, 16'h1 << i);
        end
        wr(ADDR_AUXILIARY_CONTROL_TWO, 8'h0F);
        chk({15'h0, refKeyEnable}, 16'h1);
        chk(padEnable, 16'h0);
        wr(ADDR_AUXILIARY_CONTROL_TWO, 8'h0E);
        wr(ADDR_TCTL, 8'h37);
        chk({11'h0, oscillatorSpeed, referenceSetting}, 16'h1F);
        chk({13'h0, hopCode}, 16'h0);
        wr(ADDR_MISC, 8'h40);
        wr(ADDR_TCTL, 8'h04);
        wr(ADDR_REFLO, 8'h0A);
        wr(ADDR_AUXILIARY_CONTROL_ONE, 8'h20);
        finish_conv(35, 41);
        chk({15'h0, hopCode == 3'h0}, 16'h0);
        wr(ADDR_MISC, 8'h00);
        wr(ADDR_TCTL, 8'h0C);
        wr(ADDR_AUXILIARY_CONTROL_ONE, 8'h20);
        finish_conv(70, 82);
        wr(ADDR_REFLO, 8'h00);
        wr(ADDR_AUXILIARY_CONTROL_ONE, 8'h20);
        finish_conv(0, 2);
        wr(ADDR_TCTL, 8'h04);
        wr(ADDR_REFHI, 8'h01);
        wr(ADDR_AUXILIARY_CONTROL_ONE, 8'h20);
        chk({15'h0, touchIrq}, 16'h0);
        chkreg(ADDR_TCTL, 8'h40, 8'h00);
        chkreg(ADDR_AUXILIARY_CONTROL_ONE, 8'h20, 8'h20);
        wr(ADDR_AUXILIARY_CONTROL_ONE, 8'h00);
        chkreg(ADDR_AUXILIARY_CONTROL_ONE, 8'h20, 8'h00);
        chk({15'h0, converting}, 16'h1);
        finish_conv(1019, 1025);
        wr(ADDR_AUXILIARY_CONTROL_ONE, 8'h20);
        wr(ADDR_TCTL, 8'h84);
        // The sequencer sees the power-down bit one cycle after the write.
        @(negedge sys_clk);
        chk({14'h0, converting, touchIrq}, 16'h0);
        chkreg(ADDR_TCTL, 8'h40, 8'h00);
        wr(ADDR_TCTL, 8'h3C);
        wr(ADDR_AUXILIARY_CONTROL_TWO, 8'h06);
        chk({13'h0, methodSel, oscillatorSpeed}, 16'h0);
        wr(ADDR_AUXILIARY_CONTROL_ONE, 8'h20);
        finish_conv(38, 43);
        repeat (CTK_GAP_CYC) @(negedge sys_clk);
        wr(ADDR_AUXILIARY_CONTROL_TWO, 8'h07);
        wr(ADDR_AUXILIARY_CONTROL_ONE, 8'h20);
        finish_conv(38, 43);
        print_verdict();
    end
endmodule // tks_scan_ctrl_tb

bind tks_scan_ctrl tks_scan_ctrl_monitor i_tks_scan_ctrl_monitor (
    .sys_clk(sys_clk), .srst(srst), .ce(ce), .sfrAddr(sfrAddr),
    .sfrWe(sfrWe), .sfrWdata(sfrWdata), .sfrRe(sfrRe),
    .sfrRdata(sfrRdata), .rckOsc(rckOsc), .tckOsc(tckOsc),
    .chargeFull(chargeFull), .senseEnable(senseEnable),
    .methodSel(methodSel), .refKeyEnable(refKeyEnable),
    .padEnable(padEnable), .referenceSetting(referenceSetting),
    .oscillatorSpeed(oscillatorSpeed), .hopCode(hopCode),
    .converting(converting), .touchIrq(touchIrq));
